// *** rtl/bff_pkg.sv ***
// Purpose: Constants and state type for the bidirectional FIFO port and flag block
// Assumes: Port clocks, selects and data arrive as pins sampled by clk_i
// Notes: Index 0 is port A or the A-to-B FIFO, index 1 is port B or the B-to-A FIFO

package bff_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int DATA_W = 36;
   localparam int ADDR_W = 11;
   localparam int DEPTH = 2048;
   localparam logic [11:0] CNT_FULL = 12'h800;
   localparam logic [11:0] CNT_ZERO = 12'h000;
   localparam logic [11:0] ALMOST_OFFSET = 12'h008;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] CS_RST = 2'h3;
   localparam logic [1:0] SPACE_RST = 2'h3;
   localparam logic [1:0] ALMOST_FULL_RST = 2'h3;
   localparam logic [1:0] MODE_CAPTURE_CYC = 2'h2;

   // ----------------------------------------------------------------
   // State of the whole block except the two memories
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] clk_s1;
      logic [1:0] clk_s2;
      logic [1:0] clk_q;
      logic [1:0] cs_s1;
      logic [1:0] cs_s2;
      logic [1:0] en_s1;
      logic [1:0] en_s2;
      logic [1:0] wr_s1;
      logic [1:0] wr_s2;
      logic first_word_fallthrough_select_s1;
      logic first_word_fallthrough_select_s2;
      logic mode_first_word_fallthrough_select;
      logic mode_set;
      logic [1:0] mode_cnt;
      logic [1:0][35:0] d_s1;
      logic [1:0][35:0] d_s2;
      logic [1:0][35:0] dout;
      logic [1:0][10:0] wp;
      logic [1:0][10:0] rp;
      logic [1:0][11:0] cnt;
      logic [1:0][1:0][35:0] buff;
      logic [1:0][1:0] bvld;
      logic [1:0] empty_pin;
      logic [1:0] full_pin;
      logic [1:0] aempty_n;
      logic [1:0] afull_n;
   } bff_state_t;

endpackage

// *** rtl/bff_port_flags.sv ***
// Purpose: Two opposite FIFOs with port gating, tri-state data and dual-function flags
// Assumes: Port clocks are much slower than clk_i so each edge is seen
// Notes: A two-entry buffer sits between each memory and its read port

`timescale 1ns/1ps

module bff_port_flags (
   input wire logic clk_i,                                   // 25 MHz system clock
   input wire logic rstn_i,                                  // Async reset, active low
   input wire logic port_a_clock_i,                          // Port A clock pin
   input wire logic port_b_clock_i,                          // Port B clock pin
   input wire logic port_a_chip_select_n_i,                  // Port A select, low active
   input wire logic port_b_chip_select_n_i,                  // Port B select, low active
   input wire logic port_a_transfer_enable_i,                // Port A enable, high active
   input wire logic port_b_transfer_enable_i,                // Port B enable, high active
   input wire logic port_a_write_select_i,                   // Port A: 1 write, 0 read
   input wire logic port_b_write_select_i,                   // Port B: 1 write, 0 read
   input wire logic first_word_fallthrough_select_i,         // 1 standard, 0 fall-through
   input wire logic [35:0] port_a_data_bus_i,                // Port A bus level in
   output logic [35:0] port_a_data_bus_o,                    // Port A bus drive value
   output logic port_a_data_bus_oe_o,                        // Port A bus driven
   input wire logic [35:0] port_b_data_bus_i,                // Port B bus level in
   output logic [35:0] port_b_data_bus_o,                    // Port B bus drive value
   output logic port_b_data_bus_oe_o,                        // Port B bus driven
   output logic port_a_empty_output_ready_o,                 // Empty (low) or ready (high)
   output logic port_b_empty_flag_output_ready_o,            // Empty (low) or ready (high)
   output logic port_a_full_flag_input_ready_o,              // Full (low) or ready (high)
   output logic port_b_full_flag_input_ready_o,              // Full (low) or ready (high)
   output logic port_a_almost_empty_o,                       // Low when B-to-A nearly empty
   output logic port_b_almost_empty_o,                       // Low when A-to-B nearly empty
   output logic port_a_almost_full_o,                        // Low when A-to-B nearly full
   output logic port_b_almost_full_o                         // Low when B-to-A nearly full
);

   // ----------------------------------------------------------------
   // State and memories
   // ----------------------------------------------------------------
   bff_pkg::bff_state_t st_r;
   bff_pkg::bff_state_t st_nxt;
   logic [35:0] mem [2][bff_pkg::DEPTH];
   logic [1:0] edge_p;
   logic [1:0] xfer;
   logic [1:0] wr_req;
   logic [1:0] rd_req;
   logic [1:0] we;
   logic [1:0] pop;
   logic [1:0] refill;
   logic [1:0][11:0] words;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      edge_p = 2'h0;
      xfer = 2'h0;
      wr_req = 2'h0;
      rd_req = 2'h0;
      we = 2'h0;
      pop = 2'h0;
      refill = 2'h0;
      words = '0;

      // Pins pass two flops; the first stage feeds only the second
      st_nxt.clk_s1 = {port_b_clock_i, port_a_clock_i};
      st_nxt.clk_s2 = st_r.clk_s1;
      st_nxt.clk_q = st_r.clk_s2;
      st_nxt.cs_s1 = {port_b_chip_select_n_i, port_a_chip_select_n_i};
      st_nxt.cs_s2 = st_r.cs_s1;
      st_nxt.en_s1 = {port_b_transfer_enable_i, port_a_transfer_enable_i};
      st_nxt.en_s2 = st_r.en_s1;
      st_nxt.wr_s1 = {port_b_write_select_i, port_a_write_select_i};
      st_nxt.wr_s2 = st_r.wr_s1;
      st_nxt.first_word_fallthrough_select_s1 = first_word_fallthrough_select_i;
      st_nxt.first_word_fallthrough_select_s2 = st_r.first_word_fallthrough_select_s1;
      st_nxt.d_s1[0] = port_a_data_bus_i;
      st_nxt.d_s1[1] = port_b_data_bus_i;
      st_nxt.d_s2 = st_r.d_s1;

      // Mode is caught once after reset, after the pin is through its flops
      if (!st_r.mode_set) begin
         if (st_r.mode_cnt == bff_pkg::MODE_CAPTURE_CYC) begin
            st_nxt.mode_first_word_fallthrough_select = ~st_r.first_word_fallthrough_select_s2;
            st_nxt.mode_set = 1'b1;
         end else begin
            st_nxt.mode_cnt = st_r.mode_cnt + 2'h1;
         end
      end

      // Rising port clock edge becomes a one-cycle enable
      edge_p = st_r.clk_s2 & ~st_r.clk_q;
      xfer = edge_p & ~st_r.cs_s2 & st_r.en_s2;
      wr_req = xfer & st_r.wr_s2;
      rd_req = xfer & ~st_r.wr_s2;

      // Fifo f is written by port f and read by port 1-f
      for (int f = 0; f < 2; f++) begin
         we[f] = wr_req[f] && (st_r.cnt[f] != bff_pkg::CNT_FULL);
         pop[f] = rd_req[1 - f] && st_r.bvld[f][0];
         if (pop[f]) begin
            st_nxt.buff[f][0] = st_r.buff[f][1];
            st_nxt.bvld[f] = {1'b0, st_r.bvld[f][1]};
            if (!st_r.mode_first_word_fallthrough_select) begin
               st_nxt.dout[1 - f] = st_r.buff[f][0];
            end
         end
         // Buffer slot free acts as ready toward the memory
         refill[f] = (st_r.cnt[f] != bff_pkg::CNT_ZERO) && !st_nxt.bvld[f][1];
         if (refill[f]) begin
            if (!st_nxt.bvld[f][0]) begin
               st_nxt.buff[f][0] = mem[f][st_r.rp[f]];
               st_nxt.bvld[f][0] = 1'b1;
            end else begin
               st_nxt.buff[f][1] = mem[f][st_r.rp[f]];
               st_nxt.bvld[f][1] = 1'b1;
            end
            st_nxt.rp[f] = st_r.rp[f] + 11'h001;
         end
         if (we[f]) begin
            st_nxt.wp[f] = st_r.wp[f] + 11'h001;
         end
         st_nxt.cnt[f] = st_r.cnt[f] + {11'h000, we[f]} - {11'h000, refill[f]};
         words[f] = st_nxt.cnt[f] + {11'h000, st_nxt.bvld[f][0]}
            + {11'h000, st_nxt.bvld[f][1]};
      end

      // Flags of a port move only on that port's clock edge
      for (int p = 0; p < 2; p++) begin
         if (edge_p[p]) begin
            // Low means empty, high means a word is ready; same level either mode
            st_nxt.empty_pin[p] = st_nxt.bvld[1 - p][0];
            // Low means full, high means room; same level either mode
            st_nxt.full_pin[p] = (st_nxt.cnt[p] != bff_pkg::CNT_FULL);
            st_nxt.aempty_n[p] = (words[1 - p] > bff_pkg::ALMOST_OFFSET);
            st_nxt.afull_n[p] = ((bff_pkg::CNT_FULL - st_nxt.cnt[p])
               > bff_pkg::ALMOST_OFFSET);
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '0;
         st_r.cs_s1 <= bff_pkg::CS_RST;
         st_r.cs_s2 <= bff_pkg::CS_RST;
         st_r.full_pin <= bff_pkg::SPACE_RST;
         st_r.afull_n <= bff_pkg::ALMOST_FULL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Memory has no reset; only words below the count are ever read
   always_ff @(posedge clk_i) begin
      for (int f = 0; f < 2; f++) begin
         if (we[f]) begin
            mem[f][st_r.wp[f]] <= st_r.d_s2[f];
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Fall-through shows the buffer head; standard shows the last word read
   assign port_a_data_bus_o = st_r.mode_first_word_fallthrough_select ? st_r.buff[1][0] : st_r.dout[0];
   assign port_b_data_bus_o = st_r.mode_first_word_fallthrough_select ? st_r.buff[0][0] : st_r.dout[1];
   assign port_a_data_bus_oe_o = ~st_r.cs_s2[0] & ~st_r.wr_s2[0];
   assign port_b_data_bus_oe_o = ~st_r.cs_s2[1] & ~st_r.wr_s2[1];
   assign port_a_empty_output_ready_o = st_r.empty_pin[0];
   assign port_b_empty_flag_output_ready_o = st_r.empty_pin[1];
   assign port_a_full_flag_input_ready_o = st_r.full_pin[0];
   assign port_b_full_flag_input_ready_o = st_r.full_pin[1];
   assign port_a_almost_empty_o = st_r.aempty_n[0];
   assign port_b_almost_empty_o = st_r.aempty_n[1];
   assign port_a_almost_full_o = st_r.afull_n[0];
   assign port_b_almost_full_o = st_r.afull_n[1];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   chk_oe_a_select: assert property (
      port_a_data_bus_oe_o |-> !st_r.cs_s2[0] && !st_r.wr_s2[0])
      else $error("port A bus driven while deselected");
   chk_oe_b_select: assert property (
      st_r.cs_s2[1] |-> !port_b_data_bus_oe_o)
      else $error("port B bus driven while deselected");
   chk_wp_a_gate: assert property (
      $changed(st_r.wp[0]) |-> $past(xfer[0]) && $past(st_r.en_s2[0])
         && !$past(st_r.cs_s2[0]))
      else $error("A-to-B write without port A select and enable");
   chk_wp_b_gate: assert property (
      $changed(st_r.wp[1]) |-> $past(edge_p[1]) && !$past(st_r.cs_s2[1])
         && $past(st_r.en_s2[1]))
      else $error("B-to-A write without port B edge, select and enable");
   chk_rd_b_gate: assert property (
      $fell(st_r.bvld[0][1]) |-> $past(rd_req[1]) && $past(st_r.en_s2[1]))
      else $error("A-to-B word taken without port B enable");
   chk_rd_a_gate: assert property (
      $fell(st_r.bvld[1][1]) |-> $past(rd_req[0]) && $past(st_r.en_s2[0]))
      else $error("B-to-A word taken without port A enable");
   chk_flag_a_edge: assert property (
      $changed(port_a_empty_output_ready_o) || $changed(port_a_full_flag_input_ready_o)
         |-> $past(edge_p[0]))
      else $error("port A flag moved off a port A edge");
   chk_flag_b_edge: assert property (
      $changed(port_b_empty_flag_output_ready_o) || $changed(port_b_full_flag_input_ready_o)
         || $changed(port_b_almost_full_o) || $changed(port_b_almost_empty_o)
         |-> $past(edge_p[1]))
      else $error("port B flag moved off a port B edge");
   chk_empty_b_val: assert property (
      edge_p[1] |=> port_b_empty_flag_output_ready_o == st_r.bvld[0][0])
      else $error("port B empty flag disagrees with A-to-B head");
   chk_empty_a_val: assert property (
      edge_p[0] |=> port_a_empty_output_ready_o == st_r.bvld[1][0])
      else $error("port A empty flag disagrees with B-to-A head");
   chk_full_a_val: assert property (
      edge_p[0] |=> port_a_full_flag_input_ready_o == (st_r.cnt[0] != bff_pkg::CNT_FULL))
      else $error("port A full flag disagrees with A-to-B count");
   chk_full_b_val: assert property (
      edge_p[1] |=> port_b_full_flag_input_ready_o == (st_r.cnt[1] != bff_pkg::CNT_FULL))
      else $error("port B full flag disagrees with B-to-A count");
   chk_full_no_write: assert property (
      st_r.cnt[0] == bff_pkg::CNT_FULL |=> $stable(st_r.wp[0]))
      else $error("write pointer moved while A-to-B full");
   chk_empty_no_read: assert property (
      rd_req[1] && !st_r.bvld[0][0] && !st_r.mode_first_word_fallthrough_select |=> $stable(st_r.dout[1]))
      else $error("port B output changed on a read of an empty FIFO");
   chk_mode_static: assert property (
      st_r.mode_set |=> $stable(st_r.mode_first_word_fallthrough_select) && st_r.mode_set)
      else $error("timing mode changed after capture");

   // ----------------------------------------------------------------
   // Port gating and bus direction
   // ----------------------------------------------------------------
   // A write cycle must never fight the host on the bus
   chk_oe_a_write: assert property (
      st_r.wr_s2[0] |-> !port_a_data_bus_oe_o)
      else $error("port A bus driven during a write");
   chk_oe_b_write: assert property (
      st_r.wr_s2[1] |-> !port_b_data_bus_oe_o)
      else $error("port B bus driven during a write");
   chk_pop_a_edge: assert property (
      pop[1] |-> edge_p[0] && !st_r.cs_s2[0])
      else $error("B-to-A word taken without a selected port A edge");
   chk_pop_b_edge: assert property (
      pop[0] |-> edge_p[1] && !st_r.cs_s2[1])
      else $error("A-to-B word taken without a selected port B edge");
   // Edge pulse must last one cycle, or one port edge acts twice
   chk_edge_a_pulse: assert property (
      edge_p[0] |=> !edge_p[0])
      else $error("port A edge pulse longer than one cycle");
   chk_edge_b_pulse: assert property (
      edge_p[1] |=> !edge_p[1])
      else $error("port B edge pulse longer than one cycle");

   // ----------------------------------------------------------------
   // Pointers, counts and buffers
   // ----------------------------------------------------------------
   // Count and pointers must agree, full wraps to a zero gap
   chk_ptr_a_count: assert property (
      (st_r.wp[0] - st_r.rp[0]) == st_r.cnt[0][10:0])
      else $error("A-to-B pointers disagree with count");
   chk_ptr_b_count: assert property (
      (st_r.wp[1] - st_r.rp[1]) == st_r.cnt[1][10:0])
      else $error("B-to-A pointers disagree with count");
   chk_cnt_a_bound: assert property (
      st_r.cnt[0] <= bff_pkg::CNT_FULL)
      else $error("A-to-B count above depth");
   chk_cnt_b_bound: assert property (
      st_r.cnt[1] <= bff_pkg::CNT_FULL)
      else $error("B-to-A count above depth");
   chk_full_b_write: assert property (
      st_r.cnt[1] == bff_pkg::CNT_FULL |=> $stable(st_r.wp[1]))
      else $error("write pointer moved while B-to-A full");
   chk_empty_a_rp: assert property (
      st_r.cnt[0] == bff_pkg::CNT_ZERO |=> $stable(st_r.rp[0]))
      else $error("A-to-B read pointer moved while memory empty");
   chk_empty_b_rp: assert property (
      st_r.cnt[1] == bff_pkg::CNT_ZERO |=> $stable(st_r.rp[1]))
      else $error("B-to-A read pointer moved while memory empty");
   chk_hold_a_limit: assert property (
      st_r.cnt[0] + 12'(st_r.bvld[0][0]) + 12'(st_r.bvld[0][1])
         <= bff_pkg::CNT_FULL + 12'h002)
      else $error("A-to-B holds more words than it has room for");
   chk_hold_b_limit: assert property (
      st_r.cnt[1] + 12'(st_r.bvld[1][0]) + 12'(st_r.bvld[1][1])
         <= bff_pkg::CNT_FULL + 12'h002)
      else $error("B-to-A holds more words than it has room for");
   // Second slot filled with an empty head would reorder words
   chk_buf_a_order: assert property (
      st_r.bvld[0][1] |-> st_r.bvld[0][0])
      else $error("A-to-B buffer second slot valid without head");
   chk_buf_b_order: assert property (
      st_r.bvld[1][1] |-> st_r.bvld[1][0])
      else $error("B-to-A buffer second slot valid without head");
   // A word into an empty FIFO reaches the head two cycles later
   chk_fill_a_head: assert property (
      we[0] && st_r.cnt[0] == bff_pkg::CNT_ZERO && !st_r.bvld[0][0]
         |-> ##2 st_r.bvld[0][0])
      else $error("A-to-B word did not reach the buffer head");
   chk_fill_b_head: assert property (
      we[1] && st_r.cnt[1] == bff_pkg::CNT_ZERO && !st_r.bvld[1][0]
         |-> ##2 st_r.bvld[1][0])
      else $error("B-to-A word did not reach the buffer head");

   // ----------------------------------------------------------------
   // Flags and data by mode
   // ----------------------------------------------------------------
   chk_ready_a_first_word_fallthrough_select: assert property (
      st_r.mode_first_word_fallthrough_select && edge_p[0] |=> port_a_empty_output_ready_o == st_r.bvld[1][0])
      else $error("port A output-ready disagrees with B-to-A head");
   chk_ready_b_first_word_fallthrough_select: assert property (
      st_r.mode_first_word_fallthrough_select && edge_p[1] |=> port_b_empty_flag_output_ready_o == st_r.bvld[0][0])
      else $error("port B output-ready disagrees with A-to-B head");
   chk_room_a_first_word_fallthrough_select: assert property (
      st_r.mode_first_word_fallthrough_select && edge_p[0] |=> port_a_full_flag_input_ready_o == (st_r.cnt[0] != bff_pkg::CNT_FULL))
      else $error("port A input-ready disagrees with A-to-B count");
   chk_room_b_first_word_fallthrough_select: assert property (
      st_r.mode_first_word_fallthrough_select && edge_p[1] |=> port_b_full_flag_input_ready_o == (st_r.cnt[1] != bff_pkg::CNT_FULL))
      else $error("port B input-ready disagrees with B-to-A count");
   chk_std_b_data: assert property (
      pop[0] && !st_r.mode_first_word_fallthrough_select |=> port_b_data_bus_o == $past(st_r.buff[0][0]))
      else $error("port B standard read did not show the head word");
   chk_flag_a_almost: assert property (
      $changed(port_a_almost_empty_o) || $changed(port_a_almost_full_o)
         |-> $past(edge_p[0]))
      else $error("port A almost flag moved off a port A edge");
   chk_afull_a_val: assert property (
      edge_p[0] |=> port_a_almost_full_o
         == ((bff_pkg::CNT_FULL - st_r.cnt[0]) > bff_pkg::ALMOST_OFFSET))
      else $error("port A almost-full disagrees with A-to-B count");
   chk_afull_b_val: assert property (
      edge_p[1] |=> port_b_almost_full_o
         == ((bff_pkg::CNT_FULL - st_r.cnt[1]) > bff_pkg::ALMOST_OFFSET))
      else $error("port B almost-full disagrees with B-to-A count");
   // Mode follows the synced pin, inverted: pin high is standard
   chk_mode_capture: assert property (
      !st_r.mode_set && st_r.mode_cnt == bff_pkg::MODE_CAPTURE_CYC
         |=> st_r.mode_set && (st_r.mode_first_word_fallthrough_select == !$past(st_r.first_word_fallthrough_select_s2)))
      else $error("timing mode not captured from the select pin");

   cov_write_a: cover property (we[0] ##[1:200] pop[0]);
   cov_full_a: cover property (st_r.cnt[0] == bff_pkg::CNT_FULL);
   cov_read_b_first_word_fallthrough_select: cover property (st_r.mode_first_word_fallthrough_select && pop[0]);
   cov_both_ways: cover property (we[0] && we[1]);
   cov_read_a_first_word_fallthrough_select: cover property (st_r.mode_first_word_fallthrough_select && pop[1]);

endmodule // bff_port_flags

// *** test/bff_port_host.sv ***
// Purpose: Host model for one port of the bidirectional FIFO block
// Assumes: Port clock phases last several clk_i cycles
// Notes: A bus driven by nobody shows the inverse of the block's value

`timescale 1ns/1ps

module bff_port_host (
   input wire logic clk_i,            // System clock
   input wire logic oe_i,             // Block drives the bus
   input wire logic [35:0] dout_i,    // Block drive value
   output logic pclk_o,               // Port clock
   output logic cs_n_o,               // Chip select, low active
   output logic en_o,                 // Transfer enable
   output logic wr_o,                 // 1 write, 0 read
   output logic [35:0] bus_o          // Resolved bus level
);
   logic [35:0] d;
   // Floating bus must never look like the last word
   assign bus_o = (wr_o && !cs_n_o) ? d : (oe_i ? dout_i : ~dout_i);
   initial begin
      pclk_o = 1'b0;
      cs_n_o = 1'b1;
      en_o = 1'b0;
      wr_o = 1'b0;
      d = 36'h0;
   end
   // Controls held a full port period around the rising edge
   task automatic xfer(input logic cs_n, input logic en, input logic wr, input logic [35:0] wd);
      cs_n_o = cs_n;
      en_o = en;
      wr_o = wr;
      d = wd;
      repeat (4) @(posedge clk_i);
      #1 pclk_o = 1'b1;
      repeat (5) @(posedge clk_i);
      #1 pclk_o = 1'b0;
   endtask
endmodule // bff_port_host

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the bidirectional FIFO port block
// Assumes: Index 0 is port A, index 1 port B
// Notes: Queue q[p] holds words written at port p

`timescale 1ns/1ps

module tb_top;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic first_word_fallthrough_select = 1'b1;
   integer seed = 32'h64b442d0;
   integer num_errors = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer n;
   logic [35:0] q[2][$];
   wire logic [1:0] pclk, cs_n, en, wr, oe, ef, ff, ae, af;
   wire logic [1:0][35:0] bus, dout;

   always #20 clk_i = ~clk_i;

   bff_port_host host_a (.clk_i(clk_i), .oe_i(oe[0]), .dout_i(dout[0]), .pclk_o(pclk[0]),
      .cs_n_o(cs_n[0]), .en_o(en[0]), .wr_o(wr[0]), .bus_o(bus[0]));
   bff_port_host host_b (.clk_i(clk_i), .oe_i(oe[1]), .dout_i(dout[1]), .pclk_o(pclk[1]),
      .cs_n_o(cs_n[1]), .en_o(en[1]), .wr_o(wr[1]), .bus_o(bus[1]));

   bff_port_flags bff_port_flags_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .port_a_clock_i(pclk[0]), .port_b_clock_i(pclk[1]),
      .port_a_chip_select_n_i(cs_n[0]), .port_b_chip_select_n_i(cs_n[1]),
      .port_a_transfer_enable_i(en[0]), .port_b_transfer_enable_i(en[1]),
      .port_a_write_select_i(wr[0]), .port_b_write_select_i(wr[1]),
      .first_word_fallthrough_select_i(first_word_fallthrough_select),
      .port_a_data_bus_i(bus[0]), .port_a_data_bus_o(dout[0]), .port_a_data_bus_oe_o(oe[0]),
      .port_b_data_bus_i(bus[1]), .port_b_data_bus_o(dout[1]), .port_b_data_bus_oe_o(oe[1]),
      .port_a_empty_output_ready_o(ef[0]), .port_b_empty_flag_output_ready_o(ef[1]),
      .port_a_full_flag_input_ready_o(ff[0]), .port_b_full_flag_input_ready_o(ff[1]),
      .port_a_almost_empty_o(ae[0]), .port_b_almost_empty_o(ae[1]),
      .port_a_almost_full_o(af[0]), .port_b_almost_full_o(af[1]));

   task automatic results();
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Fill and drain dominate the run; ceiling leaves some margin
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 45000) begin
         num_errors = num_errors + 1;
         results();
      end
   end

   task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic hx(input bit p, input logic c, input logic e, input logic w, input logic [35:0] d);
      if (p) host_b.xfer(c, e, w, d);
      else host_a.xfer(c, e, w, d);
   endtask

   task automatic rst(input logic mode);
      rstn_i = 1'b0;
      first_word_fallthrough_select = mode;
      repeat (20) @(posedge clk_i);
      #1 chk("rst_pins", 36'hc3, {26'h0, ae, af, oe, ef, ff});
      rstn_i = 1'b1;
      q[0].delete();
      q[1].delete();
      repeat (6) @(posedge clk_i);
      #1 chk("rst_room", 36'h3, {34'h0, ff});
   endtask

   task automatic put(input bit p, input logic c, input logic e);
      logic [35:0] d;
      logic f;
      d = 36'({$random(seed), $random(seed)});
      f = ff[p];
      hx(p, c, e, 1'b1, d);
      if (!c && e && f === 1'b1) q[p].push_back(d);
   endtask

   task automatic get(input bit p, input logic c);
      logic [35:0] old;
      old = dout[p];
      if (!first_word_fallthrough_select && q[!p].size() != 0) chk("fall_data", q[!p][0], dout[p]);
      hx(p, c, 1'b1, 1'b0, 36'h0);
      chk("bus_oe", {35'h0, !c}, {35'h0, oe[p]});
      if (!c && q[!p].size() != 0) begin
         old = q[!p].pop_front();
         if (first_word_fallthrough_select) chk("read_data", old, dout[p]);
      end else if (first_word_fallthrough_select) begin
         chk("held_data", old, dout[p]);
      end
   endtask

   // Deselected edge only refreshes this port's flags
   task automatic idle(input bit p);
      hx(p, 1'b1, 1'b1, 1'b0, 36'h0);
      chk("empty_flag", {35'h0, q[!p].size() != 0}, {35'h0, ef[p]});
   endtask

   initial begin
      rst(1'b1);
      put(0, 1'b1, 1'b1);
      put(0, 1'b0, 1'b0);
      repeat (3) put(0, 1'b0, 1'b1);
      idle(1);
      repeat (4) get(1, 1'b0);
      get(1, 1'b1);
      idle(1);
      put(1, 1'b1, 1'b1);
      put(1, 1'b0, 1'b0);
      repeat (2) put(1, 1'b0, 1'b1);
      idle(0);
      repeat (3) get(0, 1'b0);
      idle(0);
      for (int i = 0; i < 2060 && ff[0] === 1'b1; i++) put(0, 1'b0, 1'b1);
      chk("full_flag", 36'h0, {35'h0, ff[0]});
      chk("afull_flag", 36'h0, {35'h0, af[0]});
      n = q[0].size();
      chk("fill_count", 36'h1, {35'h0, n >= 2048 && n <= 2050});
      put(0, 1'b0, 1'b1);
      chk("fill_held", 36'(n), 36'(q[0].size()));
      get(1, 1'b0);
      idle(0);
      chk("room_flag", 36'h1, {35'h0, ff[0]});
      while (q[0].size() != 0) get(1, 1'b0);
      idle(1);
      chk("aempty_flag", 36'h0, {35'h0, ae[1]});
      rst(1'b0);
      put(1, 1'b0, 1'b1);
      idle(0);
      get(0, 1'b0);
      idle(0);
      chk("aempty_a", 36'h0, {35'h0, ae[0]});
      repeat (2) put(0, 1'b0, 1'b1);
      idle(1);
      repeat (2) get(1, 1'b0);
      idle(1);
      chk("ready_in", 36'hf, {32'h0, af, ff});
      results();
   end
endmodule // tb_top
